// file: design/setwi_pkg.sv
// Shared constants and types for the three-wire serial EEPROM block
package setwi_pkg;
   localparam int SETWI_MEM_BYTES = 1024;
   localparam int SETWI_BYTE_AW = 10;
   localparam int SETWI_ADDR_W = 11;
   localparam int SETWI_DATA_W = 16;
   localparam logic [4:0] SETWI_OPC_LEN_M1 = 5'h01;
   localparam logic [4:0] SETWI_ADDR_X16_M1 = 5'h09;
   localparam logic [4:0] SETWI_ADDR_X8_M1 = 5'h0a;
   localparam logic [4:0] SETWI_DATA_X16_M1 = 5'h0f;
   localparam logic [4:0] SETWI_DATA_X8_M1 = 5'h07;
   localparam logic [1:0] SETWI_OP_EXT = 2'h0;
   localparam logic [1:0] SETWI_OP_WRITE = 2'h1;
   localparam logic [1:0] SETWI_OP_READ = 2'h2;
   localparam logic [1:0] SETWI_OP_ERASE = 2'h3;
   localparam logic [1:0] SETWI_EXT_DISABLE = 2'h0;
   localparam logic [1:0] SETWI_EXT_FILL_ALL = 2'h1;
   localparam logic [1:0] SETWI_EXT_CLEAR_ALL = 2'h2;
   localparam logic [1:0] SETWI_EXT_ENABLE = 2'h3;
   localparam logic [7:0] SETWI_ERASED_BYTE = 8'hff;
   localparam int SETWI_CLK_PERIOD_PS = 8000;
   localparam longint SETWI_PROG_TIME_MS = 5;
   localparam int SETWI_PROG_CYCLES =
      int'((SETWI_PROG_TIME_MS * 64'd1000000000) / SETWI_CLK_PERIOD_PS);
   localparam logic [19:0] SETWI_PROG_CYC_W = 20'h98968;

   typedef enum logic [2:0] {
      L_IDLE, L_OPC, L_ADDR, L_DATA, L_READ, L_DONE
   } setwi_lstate_t;

   typedef enum logic [1:0] {
      K_ONE_WRITE, K_ONE_ERASE, K_ALL_WRITE, K_ALL_ERASE
   } setwi_kind_t;

   typedef struct packed {
      logic [1:0] op;
      logic [SETWI_ADDR_W-1:0] addr;
      logic [SETWI_DATA_W-1:0] data;
   } setwi_cmd_t;

   typedef struct packed {
      logic data;
      logic oe;
   } setwi_pin_t;
endpackage : setwi_pkg

// file: design/setwi_top.sv
// Three-wire serial EEPROM command, data and self-timed programming logic
// Summary of operation
// - Frame: start bit 1, two opcode bits, address, then data for writes.
// - Frame is 13 bits in 16-bit mode and 14 bits in 8-bit mode.
// - Opcodes 10 read, 11 erase, 01 write; 00 decodes two address bits.
// - Address is 11 bits (x8) or 10 bits (x16); top bit ignored.
// - Serial input bits are sampled on rising serial clock edges.
// - Output is released except during read data or status reporting.
// - Reselect during programming shows low while busy, high when ready.
// - A 1 shifted once ready releases the output on the falling edge.
// - Read sends one leading zero, then the word MSB first, rising edges.
// - Continued clocking reads following words, no zero, wrapping to 0.
// - Write starts on select fall; self-timed clear and store, no clock.
// - Erase clears the addressed location to all ones on select fall.
// - Clear-all sets every location to all ones on select fall.
// - Fill-all stores the data word in every location on select fall.
// - Program-enable latch clears at reset; set or cleared only by commands.
// - Reads work whatever the program-enable latch holds.
// - Reset leaves the device read-only with writing disabled.
// - Organization strap high selects 16-bit words, low 8-bit words.
`timescale 1ns/1ps
module setwi_top #(
   parameter int PROG_CYCLES = setwi_pkg::SETWI_PROG_CYCLES
) (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_ce,
   input wire logic i_serial_clock_in,
   input wire logic i_chip_select,
   input wire logic i_serial_input,
   input wire logic i_org_wide,
   output logic o_serial_output,
   output logic o_serial_output_oe,
   output logic o_busy,
   output logic o_program_enabled
);
   import setwi_pkg::*;

   logic [7:0] mem [SETWI_MEM_BYTES];

   // Link domain: frame state is ended by the deselect itself
   wire link_rst_n = i_rst_n & i_chip_select;

   setwi_lstate_t st_reg;
   logic [4:0] cnt_reg;
   setwi_cmd_t cmd_reg;
   logic [15:0] rdw_reg;
   setwi_pin_t rd_reg;
   logic got_start_reg;
   logic start_neg_reg;
   logic armed_reg;
   logic org_l1_reg, org_l2_reg;
   logic busy_l1_reg, busy_l2_reg;

   function automatic logic [15:0] fetch(input logic [10:0] a,
                                         input logic wide);
      logic [9:0] base;
      base = wide ? {a[8:0], 1'b0} : a[9:0];
      if (wide) begin
         fetch = {mem[base], mem[base | 10'h001]};
      end else begin
         fetch = {mem[base], 8'h00};
      end
   endfunction : fetch

   wire [10:0] addr_shift = {cmd_reg.addr[9:0], i_serial_input};
   wire [10:0] addr_inc = cmd_reg.addr + 11'h001;
   wire [4:0] addr_len_m1 = org_l2_reg ? SETWI_ADDR_X16_M1
                                       : SETWI_ADDR_X8_M1;
   wire [4:0] data_len_m1 = org_l2_reg ? SETWI_DATA_X16_M1
                                       : SETWI_DATA_X8_M1;
   wire last_bit = (cnt_reg == 5'h00);
   wire addr_done = (st_reg == L_ADDR) && last_bit;
   wire op_is_read = (cmd_reg.op == SETWI_OP_READ);
   wire op_has_data = (cmd_reg.op == SETWI_OP_WRITE) ||
      ((cmd_reg.op == SETWI_OP_EXT) &&
       ((org_l2_reg ? cmd_reg.addr[8:7] : cmd_reg.addr[9:8]) ==
        SETWI_EXT_FILL_ALL));
   wire arm_set = (addr_done && !op_is_read && !op_has_data) ||
                  ((st_reg == L_DATA) && last_bit);

   always_ff @(posedge i_serial_clock_in or negedge link_rst_n) begin
      if (!link_rst_n) begin
         st_reg <= L_IDLE;
         cnt_reg <= 5'h00;
         rdw_reg <= 16'h0000;
         rd_reg <= '0;
         got_start_reg <= 1'b0;
      end else begin
         unique case (st_reg)
            L_IDLE: begin
               if (i_serial_input && !busy_l2_reg) begin
                  got_start_reg <= 1'b1;
                  st_reg <= L_OPC;
                  cnt_reg <= SETWI_OPC_LEN_M1;
               end
            end
            L_OPC: begin
               cnt_reg <= last_bit ? addr_len_m1 : cnt_reg - 5'h01;
               if (last_bit) begin
                  st_reg <= L_ADDR;
               end
            end
            L_ADDR: begin
               if (last_bit && op_is_read) begin
                  st_reg <= L_READ;
                  rd_reg <= '{data: 1'b0, oe: 1'b1};
                  rdw_reg <= fetch(addr_shift, org_l2_reg);
                  cnt_reg <= data_len_m1;
               end else if (last_bit) begin
                  st_reg <= op_has_data ? L_DATA : L_DONE;
                  cnt_reg <= data_len_m1;
               end else begin
                  cnt_reg <= cnt_reg - 5'h01;
               end
            end
            L_DATA: begin
               cnt_reg <= cnt_reg - 5'h01;
               if (last_bit) begin
                  st_reg <= L_DONE;
               end
            end
            L_READ: begin
               rd_reg.data <= rdw_reg[15];
               if (last_bit) begin
                  rdw_reg <= fetch(addr_inc, org_l2_reg);
                  cnt_reg <= data_len_m1;
               end else begin
                  rdw_reg <= {rdw_reg[14:0], 1'b0};
                  cnt_reg <= cnt_reg - 5'h01;
               end
            end
            L_DONE: begin
               st_reg <= L_IDLE;
            end
         endcase
      end
   end

   // Command fields and the arm flag survive the deselect for the system side
   always_ff @(posedge i_serial_clock_in or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cmd_reg <= '0;
         armed_reg <= 1'b0;
         org_l1_reg <= 1'b1;
         org_l2_reg <= 1'b1;
         busy_l1_reg <= 1'b0;
         busy_l2_reg <= 1'b0;
      end else begin
         org_l1_reg <= i_org_wide;
         org_l2_reg <= org_l1_reg;
         busy_l1_reg <= o_busy;
         busy_l2_reg <= busy_l1_reg;
         armed_reg <= link_rst_n && arm_set;
         if (link_rst_n && st_reg == L_OPC) begin
            cmd_reg.op <= {cmd_reg.op[0], i_serial_input};
         end
         if (link_rst_n && st_reg == L_ADDR) begin
            cmd_reg.addr <= addr_shift;
         end
         if (link_rst_n && st_reg == L_DATA) begin
            cmd_reg.data <= {cmd_reg.data[14:0], i_serial_input};
         end
         if (link_rst_n && st_reg == L_READ && last_bit) begin
            cmd_reg.addr <= addr_inc;
         end
      end
   end

   always_ff @(negedge i_serial_clock_in or negedge link_rst_n) begin
      if (!link_rst_n) begin
         start_neg_reg <= 1'b0;
      end else begin
         start_neg_reg <= got_start_reg;
      end
   end

   // System domain
   logic cs_s1_reg, cs_s2_reg, cs_s3_reg;
   logic arm_s1_reg, arm_s2_reg;
   logic st_s1_reg, st_s2_reg;
   setwi_pin_t rd_s1_reg, rd_s2_reg;
   logic org_s1_reg, org_s2_reg;
   logic busy_reg, wel_reg, status_reg;
   setwi_kind_t kind_reg;
   setwi_cmd_t run_reg;
   logic [19:0] tmr_reg;
   logic [9:0] idx_reg;
   setwi_pin_t pin_reg;

   wire cs_fall = cs_s3_reg && !cs_s2_reg;
   wire [1:0] ext_sel = org_s2_reg ? cmd_reg.addr[9:8] : cmd_reg.addr[10:9];
   wire is_ext = (cmd_reg.op == SETWI_OP_EXT);
   wire go = cs_fall && arm_s2_reg && !busy_reg;
   wire prog_ok = go && wel_reg;
   wire start_one_wr = prog_ok && cmd_reg.op == SETWI_OP_WRITE;
   wire start_one_er = prog_ok && cmd_reg.op == SETWI_OP_ERASE;
   wire start_all_wr = prog_ok && is_ext && ext_sel == SETWI_EXT_FILL_ALL;
   wire start_all_er = prog_ok && is_ext && ext_sel == SETWI_EXT_CLEAR_ALL;
   wire start_any = start_one_wr | start_one_er | start_all_wr |
                    start_all_er;
   wire [9:0] one_base = org_s2_reg ? {cmd_reg.addr[8:0], 1'b0}
                                    : cmd_reg.addr[9:0];
   wire [7:0] one_hi = start_one_er ? SETWI_ERASED_BYTE
                     : (org_s2_reg ? cmd_reg.data[15:8] : cmd_reg.data[7:0]);
   wire [7:0] one_lo = start_one_er ? SETWI_ERASED_BYTE : cmd_reg.data[7:0];
   wire all_phase = busy_reg && (kind_reg == K_ALL_WRITE ||
                                 kind_reg == K_ALL_ERASE) &&
                    (idx_reg != 10'h3ff || tmr_reg != 20'h00000);
   wire [7:0] all_byte = (kind_reg == K_ALL_ERASE) ? SETWI_ERASED_BYTE
      : ((org_s2_reg && !idx_reg[0]) ? run_reg.data[15:8]
                                     : run_reg.data[7:0]);
   wire status_view = cs_s2_reg && status_reg;
   wire [19:0] prog_load = 20'(PROG_CYCLES - 1);

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cs_s1_reg <= 1'b0;
         cs_s2_reg <= 1'b0;
         cs_s3_reg <= 1'b0;
         arm_s1_reg <= 1'b0;
         arm_s2_reg <= 1'b0;
         st_s1_reg <= 1'b0;
         st_s2_reg <= 1'b0;
         rd_s1_reg <= '0;
         rd_s2_reg <= '0;
         org_s1_reg <= 1'b1;
         org_s2_reg <= 1'b1;
      end else if (i_ce) begin
         cs_s1_reg <= i_chip_select;
         cs_s2_reg <= cs_s1_reg;
         cs_s3_reg <= cs_s2_reg;
         arm_s1_reg <= armed_reg;
         arm_s2_reg <= arm_s1_reg;
         st_s1_reg <= start_neg_reg;
         st_s2_reg <= st_s1_reg;
         rd_s1_reg <= rd_reg;
         rd_s2_reg <= rd_s1_reg;
         org_s1_reg <= i_org_wide;
         org_s2_reg <= org_s1_reg;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wel_reg <= 1'b0;
         busy_reg <= 1'b0;
         status_reg <= 1'b0;
         kind_reg <= K_ONE_WRITE;
         run_reg <= '0;
         tmr_reg <= 20'h00000;
         idx_reg <= 10'h000;
      end else if (i_ce) begin
         if (go && is_ext && ext_sel == SETWI_EXT_ENABLE) begin
            wel_reg <= 1'b1;
         end else if (go && is_ext && ext_sel == SETWI_EXT_DISABLE) begin
            wel_reg <= 1'b0;
         end
         if (start_any) begin
            busy_reg <= 1'b1;
            status_reg <= 1'b1;
            run_reg <= cmd_reg;
            tmr_reg <= prog_load;
            idx_reg <= 10'h000;
            kind_reg <= start_all_wr ? K_ALL_WRITE
                      : start_all_er ? K_ALL_ERASE
                      : start_one_er ? K_ONE_ERASE : K_ONE_WRITE;
         end else if (busy_reg) begin
            tmr_reg <= tmr_reg - 20'h00001;
            idx_reg <= (idx_reg == 10'h3ff) ? idx_reg : idx_reg + 10'h001;
            busy_reg <= (tmr_reg != 20'h00000);
         end else if (st_s2_reg && cs_s2_reg) begin
            status_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_ce && (start_one_wr || start_one_er)) begin
         mem[one_base] <= one_hi;
         if (org_s2_reg) begin
            mem[one_base | 10'h001] <= one_lo;
         end
      end else if (i_ce && all_phase) begin
         mem[idx_reg] <= all_byte;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pin_reg <= '0;
      end else if (i_ce) begin
         if (status_view) begin
            pin_reg <= '{data: !busy_reg, oe: 1'b1};
         end else begin
            pin_reg <= '{data: rd_s2_reg.data,
                         oe: rd_s2_reg.oe && cs_s2_reg};
         end
      end
   end

   assign o_serial_output = pin_reg.data;
   assign o_serial_output_oe = pin_reg.oe;
   assign o_busy = busy_reg;
   assign o_program_enabled = wel_reg;
endmodule : setwi_top

// file: dv/setwi_top_sva.sv
// Port checker for the serial EEPROM block
`timescale 1ns/1ps
module setwi_top_sva #(
   parameter int PROG_CYCLES = setwi_pkg::SETWI_PROG_CYCLES
) (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_ce,
   input wire logic i_serial_clock_in,
   input wire logic i_chip_select,
   input wire logic i_serial_input,
   input wire logic i_org_wide,
   input wire logic o_serial_output,
   input wire logic o_serial_output_oe,
   input wire logic o_busy,
   input wire logic o_program_enabled
);
   import setwi_pkg::*;
   int busy_cnt;
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_rst_n);
   // Busy cycles counted while the system domain runs
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         busy_cnt <= 0;
      end else if (!o_busy) begin
         busy_cnt <= 0;
      end else if (i_ce) begin
         busy_cnt <= busy_cnt + 1;
      end
   end
   oe_idle_a: assert property (
      (!i_chip_select && i_ce) [*5] |-> !o_serial_output_oe)
      else $error("output driven while deselected");
   oe_select_a: assert property (
      $rose(o_serial_output_oe) |-> $past(i_chip_select))
      else $error("output enabled without select");
   busy_latch_a: assert property (
      $rose(o_busy) |-> o_program_enabled)
      else $error("programming while locked");
   busy_start_a: assert property (
      $rose(o_busy) |-> !i_chip_select && !$past(i_chip_select))
      else $error("programming started while selected");
   busy_len_a: assert property (
      $fell(o_busy) |-> busy_cnt == PROG_CYCLES)
      else $error("programming length wrong");
   status_low_a: assert property (
      o_busy && $past(o_busy, 4) && o_serial_output_oe |-> !o_serial_output)
      else $error("status not low while busy");
   status_high_a: assert property (
      $fell(o_busy) && o_serial_output_oe |-> ##[1:3] o_serial_output)
      else $error("status not high when ready");
   latch_move_a: assert property (
      $changed(o_program_enabled) |-> !i_chip_select)
      else $error("latch changed while selected");
   reset_ro_a: assert property (
      $rose(i_rst_n) |-> !o_program_enabled && !o_busy)
      else $error("not read-only after reset");
   cover property ($rose(o_busy));
   cover property (o_busy && o_serial_output_oe);
   cover property ($rose(o_program_enabled));
endmodule : setwi_top_sva

bind setwi_top setwi_top_sva #(.PROG_CYCLES(PROG_CYCLES)) u_sva (
   .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_ce(i_ce),
   .i_serial_clock_in(i_serial_clock_in), .i_chip_select(i_chip_select),
   .i_serial_input(i_serial_input), .i_org_wide(i_org_wide),
   .o_serial_output(o_serial_output),
   .o_serial_output_oe(o_serial_output_oe), .o_busy(o_busy),
   .o_program_enabled(o_program_enabled)
);

// file: dv/setwi_host.sv
// Host model driving the three-wire serial link
`timescale 1ns/1ps
module setwi_host #(
   parameter realtime HALF = 60ns
) (
   input wire logic i_clk,
   input wire logic i_sdo,
   input wire logic i_sdo_oe,
   output logic o_sclk,
   output logic o_cs,
   output logic o_sdi
);
   logic [63:0] rd;
   logic [63:0] rdoe;
   initial begin
      o_sclk = 1'b0;
      o_cs = 1'b0;
      o_sdi = 1'b0;
   end
   task automatic sel(input logic v);
      @(posedge i_clk);
      #1;
      o_cs = v;
   endtask : sel
   // Frame MSB first, then extra clocks; output sampled after each fall
   task automatic shift(input logic [63:0] v, input int n, input int nx);
      @(posedge i_clk);
      #1;
      o_cs = 1'b1;
      for (int i = 0; i <= n + nx; i++) begin
         o_sdi = (i < n) ? v[n-1-i] : 1'b0;
         #(HALF - 1ns);
         if (i > 0) begin
            rd = {rd[62:0], i_sdo};
            rdoe = {rdoe[62:0], i_sdo_oe};
         end
         #1;
         if (i == n + nx) break;
         o_sclk = 1'b1;
         #HALF;
         o_sclk = 1'b0;
      end
      // Select drops before any further rise; clock stands still
      o_cs = 1'b0;
      o_sdi = ~o_sdi;
      #300;
   endtask : shift
endmodule : setwi_host

// file: dv/setwi_tb_top.sv
// Self-checking bench for the serial EEPROM block
`timescale 1ns/1ps
module setwi_tb_top;
   import setwi_pkg::*;
   logic clk, rst_n, org_wide, sclk, cs, sdi, sdo, sdo_oe, busy, prog_en;
   int fails = 0;
   int comparisons = 0;
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   setwi_top #(.PROG_CYCLES(2000)) i_dut (
      .i_clk_sys(clk), .i_rst_n(rst_n), .i_ce(1'b1),
      .i_serial_clock_in(sclk), .i_chip_select(cs), .i_serial_input(sdi),
      .i_org_wide(org_wide), .o_serial_output(sdo),
      .o_serial_output_oe(sdo_oe), .o_busy(busy),
      .o_program_enabled(prog_en));
   setwi_host u_host (.i_clk(clk), .i_sdo(sdo), .i_sdo_oe(sdo_oe),
      .o_sclk(sclk), .o_cs(cs), .o_sdi(sdi));
   task automatic chk(input string w, input logic [15:0] e,
      input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         fails++;
         $display("BAD %s expected %h seen %h", w, e, g);
      end
   endtask : chk
   task automatic results;
      $display("fails %0d comparisons %0d", fails, comparisons);
      if (fails == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : results
   task automatic cmd(input logic [1:0] op, input logic [10:0] a,
      input logic [15:0] d, input logic nd, input int nx);
      int aw;
      int dw;
      logic [63:0] v;
      aw = org_wide ? 10 : 11;
      dw = org_wide ? 16 : 8;
      v = (64'({1'b1, op}) << aw) | 64'(a);
      if (nd) begin
         v = (v << dw) | 64'(d);
      end
      u_host.shift(v, 3 + aw + (nd ? dw : 0), nx);
   endtask : cmd
   task automatic ext(input logic [1:0] sub, input logic [15:0] d);
      cmd(SETWI_OP_EXT, 11'(sub) << (org_wide ? 8 : 9), d,
         sub == SETWI_EXT_FILL_ALL, 0);
   endtask : ext
   task automatic rdw(input logic [10:0] a, input logic [15:0] e);
      cmd(SETWI_OP_READ, a, 16'h0, 1'b0, 16);
      chk("dummy", 16'h0, {15'h0, u_host.rd[16]});
      chk("word", e, u_host.rd[15:0]);
   endtask : rdw
   task automatic wait_ready;
      int i;
      chk("busy", 16'h1, {15'h0, busy});
      u_host.sel(1'b1);
      #200;
      chk("status", 16'h2, {14'h0, sdo_oe, sdo});
      for (i = 0; i < 500 && sdo !== 1'b1; i++) #100;
      if (i == 500) begin
         fails++;
         results();
      end
      u_host.shift(64'h1, 1, 0);
      chk("release", 16'h0, {15'h0, u_host.rdoe[0]});
   endtask : wait_ready
   task automatic do_reset(input logic wide);
      rst_n = 1'b0;
      org_wide = wide;
      repeat (4) @(posedge clk);
      #1;
      rst_n = 1'b1;
      repeat (4) @(posedge clk);
      chk("rst", 16'h0, {13'h0, prog_en, busy, sdo_oe});
   endtask : do_reset
   initial begin
      do_reset(1'b1);
      cmd(SETWI_OP_WRITE, 11'h5, 16'h1234, 1'b1, 0);
      chk("locked", 16'h0, {15'h0, busy});
      ext(SETWI_EXT_ENABLE, 16'h0);
      chk("latch", 16'h1, {15'h0, prog_en});
      ext(SETWI_EXT_FILL_ALL, 16'hc3a5);
      wait_ready();
      cmd(SETWI_OP_WRITE, 11'h5, 16'h1234, 1'b1, 1);
      chk("late", 16'h0, {15'h0, busy});
      cmd(SETWI_OP_WRITE, 11'h5, 16'h5a96, 1'b1, 0);
      wait_ready();
      cmd(SETWI_OP_ERASE, 11'h1ff, 16'h0, 1'b0, 0);
      wait_ready();
      rdw(11'h5, 16'h5a96);
      rdw(11'h205, 16'h5a96);
      rdw(11'h6, 16'hc3a5);
      cmd(SETWI_OP_READ, 11'h1ff, 16'h0, 1'b0, 32);
      chk("erased", 16'hffff, u_host.rd[31:16]);
      chk("wrap", 16'hc3a5, u_host.rd[15:0]);
      ext(SETWI_EXT_CLEAR_ALL, 16'h0);
      wait_ready();
      rdw(11'h5, 16'hffff);
      ext(SETWI_EXT_DISABLE, 16'h0);
      chk("unlatch", 16'h0, {15'h0, prog_en});
      cmd(SETWI_OP_WRITE, 11'h5, 16'h0, 1'b1, 0);
      chk("locked2", 16'h0, {15'h0, busy});
      rdw(11'h5, 16'hffff);
      do_reset(1'b0);
      ext(SETWI_EXT_ENABLE, 16'h0);
      cmd(SETWI_OP_WRITE, 11'h3, 16'h5a, 1'b1, 0);
      wait_ready();
      rdw(11'h2, 16'hff5a);
      results();
   end
endmodule : setwi_tb_top
